/* tb/irq_summary_checker.sv */
// checker: apb answers, summaries and irq_n of irq_summary
// assumes binding to irq_summary, one pclk domain
`timescale 1ns/1ps
module irq_summary_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // watched ports
  input wire irq_summary_pkg::apb_req_t apb_req,
  input wire irq_summary_pkg::apb_rsp_t apb_rsp,
  input wire logic excessive_zero_error,
  input wire irq_summary_pkg::pending_t pending,
  input wire logic irq_n
);
  import irq_summary_pkg::*;
  wire [14:0] pn = pending;
  wire ez = excessive_zero_error;
  wire acc = apb_req.psel && apb_req.penable;
  wire wr = acc && apb_req.pwrite;
  wire [11:0] a = apb_req.paddr;
  wire [31:0] rd = apb_rsp.prdata;
  wire [2:0] wd = apb_req.pwdata[2:0];
  logic en_reg;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) en_reg <= 1'b0;
    else if (wr && a == 12'h140) en_reg <= wd[2];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rd(logic [11:0] x);
    apb_req.psel && !apb_req.penable && !apb_req.pwrite && a == x ##1 acc;
  endsequence
  property p_fr; s_rd(12'h100) |-> rd == {26'h0, $past(pn[13:8])}; endproperty
  property p_lk; s_rd(12'h104) |-> rd == {24'h0, $past(pn[7:0])}; endproperty
  property p_ln; s_rd(12'h0fc) |-> !rd[31:1] && (rd[0] || !$past(pn[14]));
  endproperty
  property p_irq; |pn |-> !irq_n; endproperty
  property p_err; acc && a[1:0] != 0 |-> apb_rsp.pslverr && rd == 0; endproperty
  property p_w1c; wr && a == 12'h0ec && wd == 3'h5 && !ez ##1 pn == 0 |-> irq_n;
  endproperty
  property p_en; wr && a == 12'h140 && wd == 0 ##1 pn == 0 |-> irq_n; endproperty
  property p_ez; ez && en_reg && !wr |=> !irq_n; endproperty
  a_fr: assert property (p_fr)
    else $error("framer bits");
  a_lk: assert property (p_lk)
    else $error("link bits");
  a_ln: assert property (p_ln) else $error("line bit");
  a_irq: assert property (p_irq) else $error("irq low");
  a_err: assert property (p_err) else $error("misaligned");
  a_w1c: assert property (p_w1c) else $error("flag clear");
  a_en: assert property (p_en) else $error("irq masked");
  a_ez: assert property (p_ez) else $error("irq on error");
endmodule // irq_summary_checker
bind irq_summary irq_summary_checker chk_u (.pclk, .presetn, .apb_req,
  .apb_rsp, .excessive_zero_error, .pending, .irq_n);

/* tb/tb.sv */
// testbench: random and corner apb traffic, events and pending levels
// assumes irq_summary_checker is bound to the design
`timescale 1ns/1ps
module tb;
  import irq_summary_pkg::*;
  logic pclk = 0, presetn = 0, ez = 0, er, sv = 0, irq_n;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  pending_t pend = '0;
  logic [31:0] r, d;
  logic [15:0] cnt = '0;
  logic [11:0] a, bad[3] = '{12'h4f0, 12'h0f1, 12'h144};
  logic [11:0] ad[7] = '{12'h0ec, 12'h0f0, 12'h0f4, 12'h0fc, 12'h100,
    12'h104, 12'h140};
  logic [7:0] sn;
  logic [2:0] st = '0, en = '0;
  int fails = 0, compares = 0, cyc = 0;
  always #20 pclk = ~pclk;
  irq_summary dut_u (.pclk(pclk), .presetn(presetn), .apb_req(req),
    .apb_rsp(rsp), .excessive_zero_error(ez), .pending(pend), .irq_n(irq_n));
  task automatic give_verdict;
    if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] x, input logic [31:0] v);
    req <= '{1'b1, 1'b0, w, x, v};
    @(posedge pclk);
    req.penable <= 1'b1;
    @(posedge pclk);
    while (rsp.pready !== 1'b1) @(posedge pclk);
    r = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic [31:0] exp_rd(input logic [11:0] x);
    case (x)
      12'h0ec: return {29'h0, st};
      12'h0f0: return {24'h0, cnt[15:8]};
      12'h0f4: return {24'h0, sv ? sn : cnt[7:0]};
      12'h0fc: return {31'h0, pend[14] | (|(st & en))};
      12'h100: return {26'h0, pend[13:8]};
      12'h104: return {24'h0, pend[7:0]};
      12'h140: return {29'h0, en};
      default: return '0;
    endcase
  endfunction
  task automatic pulse(input int k);
    repeat (k) begin
      ez <= 1'b1;
      @(posedge pclk);
      st = st | {2'h2, cnt == 16'hffff};
      cnt = cnt + 16'h1;
    end
    ez <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] x);
    apb(1'b0, x, '0);
    if (x < 12'h0fc) chk(r, exp_rd(x));
    else if (x == 12'h0fc) chk(r, exp_rd(x));
    else if (x == 12'h100) chk(r, exp_rd(x));
    else if (x == 12'h104) chk(r, exp_rd(x));
    else chk(r, exp_rd(x));
    chk(32'(irq_n), 32'(!(|pend || |(st & en))));
    sv = x == 12'h0f0 || (sv && x != 12'h0f4);
    sn = x == 12'h0f0 ? cnt[7:0] : sn;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(41646));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (ad[i]) rd(ad[i]);
    repeat (80) begin
      pend <= 15'($urandom);
      pulse($urandom_range(3));
      d = $urandom;
      a = ad[$urandom_range(6)];
      apb(1'b1, a, d);
      if (a == 12'h0ec) st = st & ~d[2:0];
      if (a == 12'h140) en = d[2:0] & 3'h5;
      rd(ad[$urandom_range(6)]);
    end
    pulse(65536 - int'(cnt));
    rd(12'h0f0);
    pulse(7);
    rd(12'h0f4);
    pend <= '0;
    apb(1'b1, 12'h140, '0);
    en = '0;
    rd(12'h0ec);
    apb(1'b1, 12'h0ec, 32'h0000_0005);
    st = '0;
    rd(12'h0fc);
    foreach (bad[i]) begin
      apb(1'b0, bad[i], '0);
      chk(r, 32'h0000_0000);
      chk(32'(er), 32'h0000_0001);
    end
    give_verdict();
  end
endmodule // tb

/* verilog/irq_summary.sv */
// interrupt summary, excessive-zero counter and apb register slave
// assumes pending inputs and error pulses come from logic on pclk
`timescale 1ns/1ps
module irq_summary (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire irq_summary_pkg::apb_req_t apb_req,
  output irq_summary_pkg::apb_rsp_t apb_rsp,
  // function block events and levels
  input wire logic excessive_zero_error,
  input wire irq_summary_pkg::pending_t pending,
  // interrupt pin, active low
  output logic irq_n
);
  import irq_summary_pkg::*;

  state_t st_reg;
  state_t st_next;
  logic [7:0] idx;
  logic setup;
  logic access;
  logic wr;
  logic rd_setup;
  logic own_irq;
  logic [7:0] line_summary;
  logic [7:0] framer_summary;
  logic [7:0] link_summary;
  logic [7:0] status_view;
  logic [7:0] enable_view;
  logic wrap;
  logic addr_ok;

  assign idx = apb_req.paddr[9:2];
  // misaligned or out-of-window addresses are refused, writes included
  assign addr_ok = (apb_req.paddr[1:0] == 2'b00)
                 & (apb_req.paddr[ADDR_W-1:10] == '0);
  assign setup = apb_req.psel & ~apb_req.penable;
  assign access = apb_req.psel & apb_req.penable;
  assign wr = access & apb_req.pwrite & addr_ok;
  assign rd_setup = setup & ~apb_req.pwrite;

  always_comb begin
    status_view = BYTE_RESET;
    status_view[BIT_OVERFLOW] = st_reg.counter_overflow_flag;
    status_view[BIT_EXZ] = st_reg.excessive_zero_flag;
    enable_view = BYTE_RESET;
    enable_view[BIT_OVERFLOW] = st_reg.overflow_irq_enable;
    enable_view[BIT_EXZ] = st_reg.exz_irq_enable;
  end

  // own events belong to the line decoder, so they feed the line summary
  assign own_irq = (st_reg.counter_overflow_flag
                    & st_reg.overflow_irq_enable)
                 | (st_reg.excessive_zero_flag & st_reg.exz_irq_enable);

  always_comb begin
    line_summary = BYTE_RESET;
    line_summary[0] = pending.line_side | own_irq;
    framer_summary = BYTE_RESET;
    framer_summary[5] = pending.alarm_detector;
    framer_summary[4] = pending.perf_monitor;
    framer_summary[3] = pending.pattern_gen_det;
    framer_summary[2] = pending.rx_signaling_buffer;
    framer_summary[1] = pending.frame_generator;
    framer_summary[0] = pending.frame_processor;
    link_summary[7:5] = {pending.hdlc_tx[3], pending.hdlc_tx[2],
                         pending.hdlc_tx[1]};
    link_summary[4:2] = {pending.hdlc_rx[3], pending.hdlc_rx[2],
                         pending.hdlc_rx[1]};
    link_summary[1] = pending.elastic_store;
    link_summary[0] = pending.system_interface;
  end

  assign wrap = excessive_zero_error & (st_reg.count == COUNT_MAX);

  always_comb begin
    st_next = st_reg;
    // counter wraps to zero after its last value
    if (excessive_zero_error) begin
      st_next.count = st_reg.count + 16'h0001;
    end
    // write-one clears; a same-cycle event wins
    if (wr && idx == IDX_IRQ_STATUS) begin
      if (apb_req.pwdata[BIT_OVERFLOW]) begin
        st_next.counter_overflow_flag = 1'b0;
      end
      if (apb_req.pwdata[BIT_EXZ]) begin
        st_next.excessive_zero_flag = 1'b0;
      end
    end
    if (wrap) begin
      st_next.counter_overflow_flag = 1'b1;
    end
    if (excessive_zero_error) begin
      st_next.excessive_zero_flag = 1'b1;
    end
    if (wr && idx == IDX_IRQ_ENABLE) begin
      st_next.overflow_irq_enable = apb_req.pwdata[BIT_OVERFLOW];
      st_next.exz_irq_enable = apb_req.pwdata[BIT_EXZ];
    end
    // read data and error are prepared in the setup cycle
    if (setup) begin
      st_next.rdata = '0;
      st_next.slverr = 1'b0;
      unique case (idx)
        IDX_IRQ_STATUS: st_next.rdata[7:0] = status_view;
        IDX_IRQ_ENABLE: st_next.rdata[7:0] = enable_view;
        IDX_COUNT_HIGH: st_next.rdata[7:0] = st_reg.count[15:8];
        IDX_COUNT_LOW: begin
          st_next.rdata[7:0] = st_reg.snap_valid ? st_reg.low_snap
                             : st_reg.count[7:0];
        end
        IDX_LINE_SUMMARY: st_next.rdata[7:0] = line_summary;
        IDX_FRAMER_SUMMARY: st_next.rdata[7:0] = framer_summary;
        IDX_LINK_SUMMARY: st_next.rdata[7:0] = link_summary;
        default: st_next.slverr = 1'b1;
      endcase
      if (!addr_ok) begin
        st_next.rdata = '0;
        st_next.slverr = 1'b1;
      end
    end
    // a high byte read freezes the low byte until it is read
    if (rd_setup && !st_next.slverr && idx == IDX_COUNT_HIGH) begin
      st_next.low_snap = st_reg.count[7:0];
      st_next.snap_valid = 1'b1;
    end
    if (rd_setup && !st_next.slverr && idx == IDX_COUNT_LOW) begin
      st_next.snap_valid = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg.count <= COUNT_RESET;
      st_reg.low_snap <= BYTE_RESET;
      st_reg.snap_valid <= 1'b0;
      st_reg.counter_overflow_flag <= 1'b0;
      st_reg.excessive_zero_flag <= 1'b0;
      st_reg.overflow_irq_enable <= 1'b0;
      st_reg.exz_irq_enable <= 1'b0;
      st_reg.rdata <= '0;
      st_reg.slverr <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign apb_rsp.prdata = st_reg.rdata;
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = access & st_reg.slverr;

  assign irq_n = ~(|line_summary | |framer_summary | |link_summary);

endmodule // irq_summary

/* verilog/irq_summary_pkg.sv */
// constants, register map and carrier types for the interrupt summary block
// assumes a single 25 MHz apb clock shared with all function blocks
// How it works
// - overflow flag sets on 16-bit counter wrap
// - overflow flag sticky, write one clears
// - high byte register shows counter bits 15:8
// - low byte register shows counter bits 7:0
// - line summary set by any line-side interrupt
// - framer summary bit 5: alarm detector
// - framer summary bit 4: performance monitor
// - framer summary bit 3: pattern generator/detector
// - framer summary bit 2: receive signaling buffer
// - framer summary bit 1: frame generator
// - framer summary bit 0: frame processor
// - link summary bits 7..5: hdlc transmitters 3..1
// - link summary bits 4..2: hdlc receivers 3..1
// - link summary bit 1: elastic store
// - link summary bit 0: system interface
// - overflow drives irq only when enabled
// - excessive zero sticky flag; counter counts errors
package irq_summary_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h3b;
  localparam logic [7:0] IDX_COUNT_HIGH = 8'h3c;
  localparam logic [7:0] IDX_COUNT_LOW = 8'h3d;
  localparam logic [7:0] IDX_LINE_SUMMARY = 8'h3f;
  localparam logic [7:0] IDX_FRAMER_SUMMARY = 8'h40;
  localparam logic [7:0] IDX_LINK_SUMMARY = 8'h41;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h50;

  // status and enable layout
  localparam int BIT_OVERFLOW = 0;
  localparam int BIT_EXZ = 2;
  localparam logic [7:0] STATUS_MASK = 8'h05;

  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  // pending levels from the function blocks, each already gated by
  // that block's own enables
  typedef struct packed {
    logic line_side;
    logic alarm_detector;
    logic perf_monitor;
    logic pattern_gen_det;
    logic rx_signaling_buffer;
    logic frame_generator;
    logic frame_processor;
    logic [3:1] hdlc_tx;
    logic [3:1] hdlc_rx;
    logic elastic_store;
    logic system_interface;
  } pending_t;

  typedef struct packed {
    logic [15:0] count;
    logic [7:0] low_snap;
    logic snap_valid;
    logic counter_overflow_flag;
    logic excessive_zero_flag;
    logic overflow_irq_enable;
    logic exz_irq_enable;
    logic [DATA_W-1:0] rdata;
    logic slverr;
  } state_t;

endpackage
